// ---- sgc_link_master.sv ----
`timescale 1ns/1ns
module sgc_link_master (
  input wire logic go_i,
  input wire logic [7:0] byte_i,
  output logic sclk_o,
  output logic mosi_o
);
  // The link clock stands still between frames, as a real far-end master would.
  initial begin
    sclk_o = 1'h0;
    mosi_o = 1'h0;
    forever begin
      @(posedge go_i);
      for (int i = 7; i >= 0; i--) begin
        mosi_o = byte_i[i];
        #160 sclk_o = 1'h1;
        #160 sclk_o = 1'h0;
      end
      // A released line flips so that a stale bit never passes for data.
      mosi_o = ~mosi_o;
    end
  end
endmodule

// ---- sgc_pkg.sv ----
package sgc_pkg;
  localparam logic [6:0] OFS_GCR0 = 7'h00;
  localparam logic [6:0] OFS_GCR1 = 7'h04;
  localparam logic [6:0] OFS_INT = 7'h08;
  localparam logic [6:0] OFS_LVL = 7'h0C;
  localparam logic [6:0] OFS_FLG = 7'h10;
  localparam logic [6:0] OFS_PC0 = 7'h14;
  localparam logic [6:0] OFS_PC2 = 7'h1C;
  localparam logic [6:0] OFS_DAT1 = 7'h3C;
  localparam logic [6:0] OFS_BUF = 7'h40;
  localparam logic [6:0] OFS_PEEK = 7'h44;
  localparam logic [6:0] OFS_DLY = 7'h48;
  localparam logic [6:0] OFS_DEF = 7'h4C;
  localparam logic [6:0] OFS_FMT0 = 7'h50;
  localparam logic [6:0] OFS_FMT1 = 7'h54;
  localparam logic [6:0] OFS_FMT2 = 7'h58;
  localparam logic [6:0] OFS_FMT3 = 7'h5C;
  localparam logic [6:0] OFS_VEC0 = 7'h60;
  localparam logic [6:0] OFS_VEC1 = 7'h64;
  // Global control 1 field positions.
  localparam int B_MASTER = 0;
  localparam int B_CLKSRC = 1;
  localparam int B_SLEEP = 8;
  localparam int B_LOOP = 16;
  localparam int B_XFER_EN = 24;
  localparam logic [31:0] GCR1_MASK = 32'h0101_0103;
  // Interrupt enable register fields.
  localparam int B_RX_IRQ_EN = 8;
  localparam int B_TX_IRQ_EN = 9;
  localparam int B_DMA_EN = 16;
  localparam int B_WAIT_TRI = 24;
  localparam logic [31:0] INT_MASK = 32'h0101_035F;
  localparam logic [31:0] LVL_MASK = 32'h0000_035F;
  // Flag register fields.
  localparam int B_RX_FULL = 8;
  localparam int B_TX_EMPTY = 9;
  localparam int B_OVRN = 6;
  localparam int B_BITERR = 4;
  localparam logic [31:0] FLG_W1C_MASK = 32'h0000_015F;
  localparam logic [31:0] PC0_MASK = 32'h0000_0E03;
  // Receive buffer status bits.
  localparam int B_BUF_EMPTY = 31;
  localparam int B_BUF_OVRN = 30;
  localparam int B_BUF_TXFULL = 29;
  localparam int B_BUF_BITERR = 28;
  localparam logic [31:0] BUF_RESET = 32'h8000_0000;
  localparam int B_DFSEL_LO = 24;
  // Word format: low 5 bits char length, bits 15:8 prescale, bit 17 polarity.
  localparam int B_POL = 17;
  localparam logic [4:0] CHAR_DEFAULT = 5'h10;
  localparam int WORD_W = 16;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
  } sgc_pins_t;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } sgc_req_t;
endpackage

// ---- sgc_spi_ctrl.sv ----
`timescale 1ns/1ns
// Functional notes
// - Separate transmit and receive DMA sync pulse outputs.
// - DMA pulses only while DMA request enable is set.
// - Reading receive buffer clears the receive-full flag.
// - Sleep bit freezes internal logic; clearing it resumes.
// - Register accesses still complete while asleep, clocking logic one cycle.
// - Loopback feeds transmit output to receiver; pins disconnected.
// - In loopback, clock pin idles inactive and master-in stays undriven.
// - Loopback overrun sets the same flags as normal; bit error never sets in loopback.
// - Emulation halts ignored; the block keeps running.
// - Peek register reads without side effects; buffer read clears its flags.
// - Decode offsets 0h to 64h; others reserved.
// - Reset-control bit 0 holds module in reset when zero.
// - Transfer enable low clears shifters, tx word, flags, buffers; empty reads one.
// - Clock-source bit picks external or internal clock, sets wait/select direction.
// - Direction bit chooses data pin directions; slave never makes clock.
// - Reserved control bits read zero and ignore writes.
// - Tx DMA on shift load; rx DMA on buffer load.
module sgc_spi_ctrl (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [31:0] avm_writedata_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  input wire logic sclk_in_i,
  output logic sclk_out_o,
  output logic sclk_oe_o,
  input wire logic master_out_line_i,
  output logic master_out_line_o,
  output logic master_out_line_oe_o,
  input wire logic master_in_line_i,
  output logic master_in_line_o,
  output logic master_in_line_oe_o,
  output logic cs_n_o,
  output logic cs_n_oe_o,
  output logic wait_n_o,
  output logic wait_n_oe_o,
  output logic tx_dma_sync_event_o,
  output logic rx_dma_sync_event_o,
  output logic irq_line_a_o,
  output logic irq_line_b_o
);
  logic rst_ctl_r, resetn;
  logic [31:0] gcr1_r, int_r, lvl_r, flg_r, pc0_r, dat1_r, buf_r, dly_r, def_r;
  logic [31:0] fmt_r [4];
  logic ack_r, acc_go, run;
  logic [sgc_pkg::WORD_W-1:0] txsh_r, rxsh_r, rxword_r;
  logic [4:0] cnt_r;
  logic busy_r, tx_pend_r, sclk_int_r, rx_done, shift_load;
  logic [7:0] pre_r;
  logic [2:0] sck_s_r, miso_s_r, mosi_s_r;
  logic ext_edge_prev_r;
  logic [31:0] rdata_nxt;
  logic [31:0] fmt_sel;
  logic master, loop, xen, pol;
  logic serial_in, sample_edge, shift_edge;
  logic irq_a_nxt, irq_b_nxt;
  sgc_pkg::sgc_pins_t pins_q;

  function automatic logic [31:0] rmask(input logic [31:0] v, input logic [31:0] m);
    return v & m;
  endfunction

  assign master = gcr1_r[sgc_pkg::B_MASTER];
  assign loop = gcr1_r[sgc_pkg::B_LOOP];
  assign xen = gcr1_r[sgc_pkg::B_XFER_EN];
  assign fmt_sel = fmt_r[dat1_r[sgc_pkg::B_DFSEL_LO +: 2]];
  assign pol = fmt_sel[sgc_pkg::B_POL];
  // One wait state per access; the read or write commits on the acked edge.
  assign acc_go = (avm_read_i | avm_write_i) & ack_r;
  // Sleep gating. Each access lets the logic run for that one cycle.
  assign run = ~gcr1_r[sgc_pkg::B_SLEEP] | acc_go;
  // No halt input: only the reset input, the sleep bit, the reset-control bit or transfer enable can stop the block.
  assign resetn = rst_n_i & rst_ctl_r;
  // Settled pin levels, taken only from the third sampler stage.
  assign pins_q = {sck_s_r[2], mosi_s_r[2], miso_s_r[2]};

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avm_read_i | avm_write_i) & ~ack_r;
    end
  end

  // Three-flop samplers on all pins; a change counts once stages two and three agree.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sck_s_r <= 3'h0;
      miso_s_r <= 3'h0;
      mosi_s_r <= 3'h0;
      ext_edge_prev_r <= 1'b0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], sclk_in_i};
      miso_s_r <= {miso_s_r[1:0], master_in_line_i};
      mosi_s_r <= {mosi_s_r[1:0], master_out_line_i};
      if (sck_s_r[1] == sck_s_r[2]) begin
        ext_edge_prev_r <= sck_s_r[2];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rst_ctl_r <= 1'b0;
    end else if (acc_go && avm_write_i && avm_address_i == sgc_pkg::OFS_GCR0) begin
      rst_ctl_r <= avm_writedata_i[0];
    end
  end

  // Control, interrupt, level and pin writes are masked so reserved bits never store; delay and format keep every bit.
  always_ff @(posedge mclk_i) begin
    if (!resetn) begin
      gcr1_r <= 32'h0000_0000;
      int_r <= 32'h0000_0000;
      lvl_r <= 32'h0000_0000;
      pc0_r <= 32'h0000_0000;
      dly_r <= 32'h0000_0000;
      def_r <= 32'h0000_00FF;
      for (int i = 0; i < 4; i++) begin
        fmt_r[i] <= {27'h0, sgc_pkg::CHAR_DEFAULT};
      end
    end else if (acc_go && avm_write_i) begin
      case (avm_address_i)
        sgc_pkg::OFS_GCR1: gcr1_r <= rmask(avm_writedata_i, sgc_pkg::GCR1_MASK);
        sgc_pkg::OFS_INT: int_r <= rmask(avm_writedata_i, sgc_pkg::INT_MASK);
        sgc_pkg::OFS_LVL: lvl_r <= rmask(avm_writedata_i, sgc_pkg::LVL_MASK);
        sgc_pkg::OFS_PC0: pc0_r <= rmask(avm_writedata_i, sgc_pkg::PC0_MASK);
        sgc_pkg::OFS_DLY: dly_r <= avm_writedata_i;
        sgc_pkg::OFS_DEF: def_r <= {24'h0, avm_writedata_i[7:0]};
        sgc_pkg::OFS_FMT0: fmt_r[0] <= avm_writedata_i;
        sgc_pkg::OFS_FMT1: fmt_r[1] <= avm_writedata_i;
        sgc_pkg::OFS_FMT2: fmt_r[2] <= avm_writedata_i;
        sgc_pkg::OFS_FMT3: fmt_r[3] <= avm_writedata_i;
        default: ;
      endcase
    end
  end

  // Internal clock source drives the serial clock; slave never does.
  // Loopback takes the transmit bit straight back in.
  assign serial_in = loop ? txsh_r[sgc_pkg::WORD_W-1] : (master ? pins_q.miso : pins_q.mosi);
  // The internal clock toggles once per prescale period; data is taken on the leading edge.
  assign sample_edge = master && gcr1_r[sgc_pkg::B_CLKSRC] ? (pre_r == 8'h00 && sclk_int_r == pol)
                     : (sck_s_r[1] == sck_s_r[2] && sck_s_r[2] != ext_edge_prev_r && sck_s_r[2] != pol);
  assign shift_edge = master && gcr1_r[sgc_pkg::B_CLKSRC] ? (pre_r == 8'h00 && sclk_int_r != pol)
                    : (sck_s_r[1] == sck_s_r[2] && sck_s_r[2] != ext_edge_prev_r && sck_s_r[2] == pol);
  // A word written mid-character waits in the pending slot until the shifter is free.
  assign shift_load = tx_pend_r && !busy_r;
  assign rx_done = busy_r && sample_edge && cnt_r == 5'h01;

  // Transmit word, shifters and bit counter.
  always_ff @(posedge mclk_i) begin
    if (!resetn || !xen) begin
      // Transfer disable clears shifters and the transmit word.
      dat1_r <= 32'h0000_0000;
      txsh_r <= '0;
      rxsh_r <= '0;
      cnt_r <= 5'h00;
      busy_r <= 1'b0;
      tx_pend_r <= 1'b0;
      pre_r <= 8'h00;
      sclk_int_r <= 1'b0;
    end else if (run) begin
      if (acc_go && avm_write_i && avm_address_i == sgc_pkg::OFS_DAT1) begin
        dat1_r <= avm_writedata_i;
        tx_pend_r <= 1'b1;
      end else if (shift_load) begin
        tx_pend_r <= 1'b0;
      end
      pre_r <= (pre_r == 8'h00) ? fmt_sel[15:8] : pre_r - 8'h01;
      if (!busy_r) begin
        sclk_int_r <= pol;
      end else if (pre_r == 8'h00) begin
        sclk_int_r <= ~sclk_int_r;
      end
      if (shift_load) begin
        txsh_r <= dat1_r[sgc_pkg::WORD_W-1:0] << (5'(sgc_pkg::WORD_W) - fmt_sel[4:0]);
        cnt_r <= fmt_sel[4:0];
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (sample_edge) begin
          rxsh_r <= {rxsh_r[sgc_pkg::WORD_W-2:0], serial_in};
          cnt_r <= cnt_r - 5'h01;
          busy_r <= cnt_r != 5'h01;
        end
        if (shift_edge) begin
          txsh_r <= {txsh_r[sgc_pkg::WORD_W-2:0], 1'b0};
        end
      end
    end
  end

  // Internal receive holding word, cleared with the transfer enable like the buffer.
  always_ff @(posedge mclk_i) begin
    if (!resetn || !xen) begin
      rxword_r <= '0;
    end else if (run && rx_done) begin
      rxword_r <= {rxsh_r[sgc_pkg::WORD_W-2:0], serial_in};
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge mclk_i) begin
    if (!resetn || !xen) begin
      // Flags and buffer cleared, empty bit reads one.
      flg_r <= 32'h0000_0000;
      buf_r <= sgc_pkg::BUF_RESET;
    end else if (run) begin
      if (acc_go && avm_write_i && avm_address_i == sgc_pkg::OFS_FLG) begin
        flg_r <= flg_r & ~rmask(avm_writedata_i, sgc_pkg::FLG_W1C_MASK);
      end
      // Buffer read clears receive-full, sets the empty bit and clears the overrun and bit error buffer bits.
      if (acc_go && avm_read_i && avm_address_i == sgc_pkg::OFS_BUF) begin
        flg_r[sgc_pkg::B_RX_FULL] <= 1'b0;
        buf_r[sgc_pkg::B_BUF_EMPTY] <= 1'b1;
        buf_r[sgc_pkg::B_BUF_OVRN] <= 1'b0;
        buf_r[sgc_pkg::B_BUF_BITERR] <= 1'b0;
      end
      flg_r[sgc_pkg::B_TX_EMPTY] <= ~tx_pend_r;
      buf_r[sgc_pkg::B_BUF_TXFULL] <= tx_pend_r;
      if (rx_done) begin
        buf_r[sgc_pkg::WORD_W-1:0] <= {rxsh_r[sgc_pkg::WORD_W-2:0], serial_in};
        buf_r[sgc_pkg::B_BUF_EMPTY] <= 1'b0;
        flg_r[sgc_pkg::B_RX_FULL] <= 1'b1;
        // Overrun acts the same in loopback; the bit error check below never fires there.
        if (!buf_r[sgc_pkg::B_BUF_EMPTY]) begin
          flg_r[sgc_pkg::B_OVRN] <= 1'b1;
          buf_r[sgc_pkg::B_BUF_OVRN] <= 1'b1;
        end
      end
      // The echo comes back through the samplers, so this check needs half bits longer than four clocks.
      if (busy_r && master && sample_edge && (loop ? 1'b0 : pins_q.mosi) != txsh_r[sgc_pkg::WORD_W-1] && !loop) begin
        flg_r[sgc_pkg::B_BITERR] <= 1'b1;
        buf_r[sgc_pkg::B_BUF_BITERR] <= 1'b1;
      end
    end
  end

  // DMA sync pulses on shift load and buffer load, gated by enable.
  always_ff @(posedge mclk_i) begin
    if (!resetn) begin
      tx_dma_sync_event_o <= 1'b0;
      rx_dma_sync_event_o <= 1'b0;
    end else begin
      tx_dma_sync_event_o <= run && xen && shift_load && int_r[sgc_pkg::B_DMA_EN];
      rx_dma_sync_event_o <= run && xen && rx_done && int_r[sgc_pkg::B_DMA_EN];
    end
  end

  // Each enabled flag drives the line picked by its level bit; both lines are levels.
  always_comb begin
    irq_a_nxt = 1'b0;
    irq_b_nxt = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (flg_r[i] && int_r[i]) begin
        if (lvl_r[i]) begin
          irq_b_nxt = 1'b1;
        end else begin
          irq_a_nxt = 1'b1;
        end
      end
    end
  end

  // Pin drive: loopback idles the clock and releases data pins.
  always_ff @(posedge mclk_i) begin
    if (!resetn) begin
      sclk_out_o <= 1'b0;
      sclk_oe_o <= 1'b0;
      master_out_line_o <= 1'b0;
      master_out_line_oe_o <= 1'b0;
      master_in_line_o <= 1'b0;
      master_in_line_oe_o <= 1'b0;
      cs_n_o <= 1'b1;
      cs_n_oe_o <= 1'b0;
      wait_n_o <= 1'b1;
      wait_n_oe_o <= 1'b0;
      irq_line_a_o <= 1'b0;
      irq_line_b_o <= 1'b0;
    end else begin
      sclk_out_o <= loop ? pol : sclk_int_r;
      sclk_oe_o <= master && gcr1_r[sgc_pkg::B_CLKSRC];
      master_out_line_o <= txsh_r[sgc_pkg::WORD_W-1];
      master_out_line_oe_o <= master && !loop;
      master_in_line_o <= txsh_r[sgc_pkg::WORD_W-1];
      master_in_line_oe_o <= !master && !loop && busy_r;
      cs_n_o <= !(busy_r && master);
      // Clock source sets the select and wait pin directions.
      cs_n_oe_o <= gcr1_r[sgc_pkg::B_CLKSRC];
      wait_n_o <= !(tx_pend_r || busy_r);
      wait_n_oe_o <= !gcr1_r[sgc_pkg::B_CLKSRC] && !(int_r[sgc_pkg::B_WAIT_TRI] && !(tx_pend_r || busy_r));
      irq_line_a_o <= irq_a_nxt;
      irq_line_b_o <= irq_b_nxt;
    end
  end

  // Read decode; peek reads the buffer with no side effect.
  always_comb begin
    case (avm_address_i)
      sgc_pkg::OFS_GCR0: rdata_nxt = {31'h0, rst_ctl_r};
      sgc_pkg::OFS_GCR1: rdata_nxt = gcr1_r;
      sgc_pkg::OFS_INT: rdata_nxt = int_r;
      sgc_pkg::OFS_LVL: rdata_nxt = lvl_r;
      sgc_pkg::OFS_FLG: rdata_nxt = flg_r;
      sgc_pkg::OFS_PC0: rdata_nxt = pc0_r;
      sgc_pkg::OFS_PC2: rdata_nxt = {29'h0, pins_q.mosi, pins_q.miso, pins_q.sclk};
      sgc_pkg::OFS_DAT1: rdata_nxt = dat1_r;
      sgc_pkg::OFS_BUF: rdata_nxt = buf_r;
      sgc_pkg::OFS_PEEK: rdata_nxt = buf_r;
      sgc_pkg::OFS_DLY: rdata_nxt = dly_r;
      sgc_pkg::OFS_DEF: rdata_nxt = def_r;
      sgc_pkg::OFS_FMT0: rdata_nxt = fmt_r[0];
      sgc_pkg::OFS_FMT1: rdata_nxt = fmt_r[1];
      sgc_pkg::OFS_FMT2: rdata_nxt = fmt_r[2];
      sgc_pkg::OFS_FMT3: rdata_nxt = fmt_r[3];
      sgc_pkg::OFS_VEC0: rdata_nxt = {31'h0, irq_line_a_o};
      sgc_pkg::OFS_VEC1: rdata_nxt = {31'h0, irq_line_b_o};
      default: rdata_nxt = sgc_pkg::RDATA_ZERO;
    endcase
  end

  // Read data registered on the wait cycle so it stands at the acked edge.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      avm_readdata_o <= sgc_pkg::RDATA_ZERO;
      avm_waitrequest_o <= 1'b1;
    end else begin
      avm_readdata_o <= rdata_nxt;
      avm_waitrequest_o <= !((avm_read_i | avm_write_i) & ~ack_r);
    end
  end
endmodule

// ---- sgc_spi_ctrl_monitor.sv ----
`timescale 1ns/1ns
module sgc_spi_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [31:0] avm_writedata_i,
  input wire logic avm_waitrequest_o,
  input wire logic sclk_out_o,
  input wire logic sclk_oe_o,
  input wire logic master_out_line_oe_o,
  input wire logic master_in_line_oe_o,
  input wire logic cs_n_oe_o,
  input wire logic tx_dma_sync_event_o,
  input wire logic rx_dma_sync_event_o
);
  logic g0_r;
  logic [31:0] g1_r;
  logic [31:0] int_r;
  logic [1:0] quiet_r;
  wire wr_ok = avm_write_i && !avm_waitrequest_o;
  wire dma_on = int_r[sgc_pkg::B_DMA_EN] && g1_r[sgc_pkg::B_XFER_EN];
  wire loop_on = g1_r[sgc_pkg::B_LOOP];
  wire clk_int = g1_r[sgc_pkg::B_CLKSRC];
  wire asleep = g1_r[sgc_pkg::B_SLEEP];
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i)
      g0_r <= 1'h0;
    else if (wr_ok && avm_address_i == sgc_pkg::OFS_GCR0)
      g0_r <= avm_writedata_i[0];
  end
  // Shadows clear with the reset-control bit, as the block's own registers do.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !g0_r) begin
      g1_r <= 32'h0;
      int_r <= 32'h0;
    end else if (wr_ok && avm_address_i == sgc_pkg::OFS_GCR1)
      g1_r <= avm_writedata_i;
    else if (wr_ok && avm_address_i == sgc_pkg::OFS_INT)
      int_r <= avm_writedata_i;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !avm_waitrequest_o)
      quiet_r <= 2'h0;
    else if (quiet_r != 2'h3)
      quiet_r <= quiet_r + 2'h1;
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_req;
    $rose(avm_read_i || avm_write_i);
  endsequence
  sequence s_ack;
    ##[1:2] !avm_waitrequest_o;
  endsequence
  property p_req_ack;
    s_req |-> s_ack;
  endproperty
  a_req_ack: assert property (p_req_ack) else $error("bus answer late");
  property p_ack_one;
    $fell(avm_waitrequest_o) |=> avm_waitrequest_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dma_pulse;
    (tx_dma_sync_event_o |=> !tx_dma_sync_event_o) and (rx_dma_sync_event_o |=> !rx_dma_sync_event_o);
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma event not a pulse");
  property p_dma_gate;
    tx_dma_sync_event_o || rx_dma_sync_event_o |-> dma_on || $past(dma_on);
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma event while disabled");
  property p_loop_quiet;
    loop_on && $past(loop_on, 2) |-> !master_in_line_oe_o && !master_out_line_oe_o && $stable(sclk_out_o);
  endproperty
  a_loop_quiet: assert property (p_loop_quiet) else $error("pins active in loopback");
  property p_slave_noclk;
    !clk_int && !$past(clk_int) |-> !sclk_oe_o;
  endproperty
  a_slave_noclk: assert property (p_slave_noclk) else $error("clock driven with external source");
  property p_cs_dir;
    $stable(clk_int) |-> cs_n_oe_o == clk_int;
  endproperty
  a_cs_dir: assert property (p_cs_dir) else $error("select direction wrong");
  property p_sleep_freeze;
    asleep && $past(asleep, 3) && quiet_r == 2'h3 |-> !tx_dma_sync_event_o && !rx_dma_sync_event_o;
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("activity while asleep");
endmodule
bind sgc_spi_ctrl sgc_spi_ctrl_monitor sgc_spi_ctrl_monitor_i (.*);

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
  logic mclk, rst_n, rd, wr, go, sck, sck_oe, mo_o, mo_oe, mi_o, mi_oe, cs_oe, wait_o, tx_ev, rx_ev, m_sck, m_mosi;
  logic irq_a, irq_b, wait_n, wait_oe;
  logic [6:0] addr;
  logic [31:0] wdat, rdat, q;
  int n_fail = 0, checks_done = 0, n_tx = 0, n_rx = 0, b, c;
  wire sck_pin = sck_oe ? sck : m_sck;
  wire mo_pin = mo_oe ? mo_o : m_mosi;
  wire mi_pin = mi_oe ? mi_o : ~mo_pin;
  sgc_spi_ctrl sgc_spi_ctrl_i (.mclk_i(mclk), .rst_n_i(rst_n), .avm_address_i(addr), .avm_read_i(rd),
    .avm_write_i(wr), .avm_writedata_i(wdat), .avm_readdata_o(rdat), .avm_waitrequest_o(wait_o),
    .sclk_in_i(sck_pin), .sclk_out_o(sck), .sclk_oe_o(sck_oe), .master_out_line_i(mo_pin),
    .master_out_line_o(mo_o), .master_out_line_oe_o(mo_oe), .master_in_line_i(mi_pin),
    .master_in_line_o(mi_o), .master_in_line_oe_o(mi_oe), .cs_n_o(), .cs_n_oe_o(cs_oe), .wait_n_o(wait_n),
    .wait_n_oe_o(wait_oe), .tx_dma_sync_event_o(tx_ev), .rx_dma_sync_event_o(rx_ev), .irq_line_a_o(irq_a),
    .irq_line_b_o(irq_b));
  sgc_link_master sgc_link_master_i (.go_i(go), .byte_i(8'hC3), .sclk_o(m_sck), .mosi_o(m_mosi));
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (tx_ev === 1'h1) n_tx++;
    if (rx_ev === 1'h1) n_rx++;
  end
  task automatic print_verdict();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The request stays up until waitrequest is sampled low; the release costs one edge.
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n = 0;
    addr <= a;
    wdat <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_o !== 1'h0 && n < 50);
    q = rdat;
    if (wait_o !== 1'h0) begin
      n_fail++;
      print_verdict();
    end
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'h0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic poll(input int k = sgc_pkg::B_RX_FULL);
    int n = 0;
    do begin
      bus(1'h0, sgc_pkg::OFS_FLG, 32'h0);
      n++;
    end while (q[k] !== 1'h1 && n < 100);
    if (q[k] !== 1'h1) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic s_regs();
    bus(1'h1, sgc_pkg::OFS_GCR0, 32'hFFFF_FFFF);
    rd_chk(sgc_pkg::OFS_GCR0, 32'h0000_0001);
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'hFFFF_FFFF);
    rd_chk(sgc_pkg::OFS_GCR1, 32'h0101_0103);
    bus(1'h1, sgc_pkg::OFS_GCR0, 32'h0);
    rd_chk(sgc_pkg::OFS_GCR1, 32'h0);
    bus(1'h1, sgc_pkg::OFS_GCR0, 32'h0000_0001);
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'h0);
    rd_chk(sgc_pkg::OFS_BUF, 32'h8000_0000);
    rd_chk(7'h68, 32'h0);
  endtask
  task automatic s_loop();
    bus(1'h1, sgc_pkg::OFS_FMT0, 32'h0000_0108);
    bus(1'h1, sgc_pkg::OFS_INT, 32'h0001_0000);
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'h0101_0003);
    b = n_rx;
    c = n_tx;
    bus(1'h1, sgc_pkg::OFS_DAT1, 32'h0000_00A5);
    poll();
    chk({28'h0, sck_oe, sck, mo_oe, mi_oe}, 32'h0000_0008);
    chk(n_tx - c, 1);
    rd_chk(sgc_pkg::OFS_PEEK, 32'h0000_00A5, 32'h8000_00FF);
    rd_chk(sgc_pkg::OFS_FLG, 32'h0000_0100, 32'h0000_0100);
    rd_chk(sgc_pkg::OFS_BUF, 32'h0000_00A5, 32'h8000_00FF);
    rd_chk(sgc_pkg::OFS_FLG, 32'h0, 32'h0000_0100);
    chk(n_rx - b, 1);
  endtask
  task automatic s_xfer();
    bus(1'h1, sgc_pkg::OFS_INT, 32'h0);
    b = n_rx;
    c = n_tx;
    bus(1'h1, sgc_pkg::OFS_DAT1, 32'h0000_005A);
    poll();
    bus(1'h1, sgc_pkg::OFS_DAT1, 32'h0000_005A);
    poll(sgc_pkg::B_OVRN);
    chk(n_rx - b + n_tx - c, 0);
    rd_chk(sgc_pkg::OFS_PEEK, 32'h4000_005A, 32'hC000_00FF);
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'h0001_0003);
    rd_chk(sgc_pkg::OFS_FLG, 32'h0);
    rd_chk(sgc_pkg::OFS_BUF, 32'h8000_0000);
    rd_chk(sgc_pkg::OFS_DAT1, 32'h0, 32'h0000_FFFF);
  endtask
  task automatic s_sleep();
    bus(1'h1, sgc_pkg::OFS_INT, 32'h0001_0000);
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'h0101_0103);
    b = n_rx;
    bus(1'h1, sgc_pkg::OFS_DAT1, 32'h0000_0033);
    repeat (100) @(posedge mclk);
    rd_chk(sgc_pkg::OFS_FLG, 32'h0, 32'h0000_0100);
    rd_chk(sgc_pkg::OFS_GCR1, 32'h0101_0103);
    chk(n_rx - b, 0);
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'h0101_0003);
    poll();
    chk(n_rx - b, 1);
    rd_chk(sgc_pkg::OFS_BUF, 32'h0000_0033, 32'h8000_00FF);
  endtask
  task automatic s_slave();
    bus(1'h1, sgc_pkg::OFS_GCR1, 32'h0100_0000);
    b = n_rx;
    bus(1'h1, sgc_pkg::OFS_DAT1, 32'h0000_00C3);
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    poll();
    chk({29'h0, sck_oe, mo_oe, cs_oe}, 32'h0);
    chk(n_rx - b, 1);
    chk({30'h0, wait_oe, wait_n}, 32'h0000_0003);
    bus(1'h1, sgc_pkg::OFS_INT, 32'h0000_0100);
    rd_chk(sgc_pkg::OFS_VEC0, 32'h0000_0001);
    chk({30'h0, irq_a, irq_b}, 32'h0000_0002);
    bus(1'h1, sgc_pkg::OFS_LVL, 32'h0000_0100);
    rd_chk(sgc_pkg::OFS_VEC1, 32'h0000_0001);
    chk({30'h0, irq_a, irq_b}, 32'h0000_0001);
    rd_chk(sgc_pkg::OFS_BUF, 32'h0000_00C3, 32'h8000_00FF);
    rd_chk(sgc_pkg::OFS_VEC1, 32'h0);
    chk({30'h0, irq_a, irq_b}, 32'h0);
  endtask
  initial begin
    rst_n = 1'h0;
    rd = 1'h0;
    wr = 1'h0;
    go = 1'h0;
    addr = 7'h00;
    wdat = 32'h0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    s_regs();
    s_loop();
    s_xfer();
    s_sleep();
    s_slave();
    print_verdict();
  end
endmodule
